/* common/crv_pkg.sv */
// Overview of operation
// (RULE_01) Preset row field sets first row scan of the top character row.
// (RULE_02) Byte pan field offsets the start address by zero to three bytes.
// (RULE_03) Maximum scan line field is scan lines per character row minus one.
// (RULE_04) Line doubling repeats row scan and memory address for every line.
// (RULE_05) Cursor start is first row minus one; start above end gives no cursor.
// (RULE_06) Cursor disable bit set hides the text cursor.
// (RULE_07) Cursor ends on the row given by the cursor end field.
// (RULE_08) Cursor delay code delays the cursor zero to three character clocks.
// (RULE_09) Each frame starts at the 21-bit display start address.
// (RULE_10) Cursor shows where memory address equals 21-bit cursor location.
// (RULE_11) Vertical sync starts when line counter equals 11-bit start value.
// (RULE_12) Vertical sync ends when low four line bits match the end field.
// (RULE_13) End of active display sets the vertical interrupt flip-flop.
// (RULE_14) Clear bit at zero clears and holds the flip-flop; one re-arms it.
// (RULE_15) Software writes clear bit zero then one, other bits unchanged.
// (RULE_16) Interrupt passes only with disable clear and master enable set.
// (RULE_17) Refresh select gives three or five cycles unless overridden.
// (RULE_18) Write lock blocks timing register writes except split line bit 8.
// (RULE_19) Active display ends after vertical display end plus one lines.
// (RULE_20) Row start advances by offset times two, four or eight.
// (RULE_21) Offset bits 9-8 from pitch extension, else bit 8 from second register.
// (RULE_22) Word and doubleword bits pick row mode; force bit sets doubleword. Code ignores word_mode_i: quadword x8, dword or force x4, else x2.
// (RULE_23) Host writes an index, then data accesses reach the indexed register.
package crv_pkg;
	localparam logic [7:0] CRV_IDX_PRESET = 8'h08;
	localparam logic [7:0] CRV_IDX_MAXSCAN = 8'h09;
	localparam logic [7:0] CRV_IDX_CSTART = 8'h0A;
	localparam logic [7:0] CRV_IDX_CEND = 8'h0B;
	localparam logic [7:0] CRV_IDX_STARTH = 8'h0C;
	localparam logic [7:0] CRV_IDX_STARTL = 8'h0D;
	localparam logic [7:0] CRV_IDX_CLOCH = 8'h0E;
	localparam logic [7:0] CRV_IDX_CLOCL = 8'h0F;
	localparam logic [7:0] CRV_IDX_VSSTART = 8'h10;
	localparam logic [7:0] CRV_IDX_VSEND = 8'h11;
	localparam logic [7:0] CRV_IDX_VDEND = 8'h12;
	localparam logic [7:0] CRV_IDX_PITCH = 8'h13;
	localparam logic [7:0] CRV_IDX_OVFL = 8'h07;
	localparam logic [7:0] CRV_IDX_LOCKED_LAST = 8'h07;
	// Read masks: reserved bits read as zero
	localparam logic [7:0] CRV_MASK_PRESET = 8'h7F;
	localparam logic [7:0] CRV_MASK_CSTART = 8'h3F;
	localparam logic [7:0] CRV_MASK_CEND = 8'h7F;
	localparam logic [7:0] CRV_MASK_ALL = 8'hFF;
	localparam logic [7:0] CRV_MASK_NONE = 8'h00;
	localparam logic [7:0] CRV_OVFL_UNLOCKED = 8'h10;
	// Reset values
	localparam logic [7:0] CRV_RST_ZERO = 8'h00;
	localparam logic [7:0] CRV_RST_VSEND = 8'h80;
	// Field positions
	localparam int CRV_ROW_LSB = 0;
	localparam int CRV_ROW_MSB = 4;
	localparam int CRV_PAN_LSB = 5;
	localparam int CRV_PAN_MSB = 6;
	localparam int CRV_DBL_BIT = 7;
	localparam int CRV_COFF_BIT = 5;
	localparam int CRV_VSE_MSB = 3;
	localparam int CRV_CLR_BIT = 4;
	localparam int CRV_DIS_BIT = 5;
	localparam int CRV_REF_BIT = 6;
	localparam int CRV_LOCK_BIT = 7;
	localparam int CRV_PEXT_LSB = 4;
	localparam int CRV_PEXT_MSB = 5;
	localparam int CRV_P8_BIT = 2;
	localparam int CRV_EXT_MSB = 4;
	// Refresh cycles per line
	localparam logic [2:0] CRV_REF_THREE = 3'h3;
	localparam logic [2:0] CRV_REF_FIVE = 3'h5;
	localparam logic [2:0] CRV_REF_ONE = 3'h1;
	localparam logic [1:0] CRV_OVR_NONE = 2'h0;
	localparam logic [1:0] CRV_OVR_ONE = 2'h1;
	localparam logic [1:0] CRV_OVR_THREE = 2'h2;
	// Row address shift: word x2, doubleword x4, quadword x8
	localparam logic [1:0] CRV_SH_WORD = 2'h1;
	localparam logic [1:0] CRV_SH_DWORD = 2'h2;
	localparam logic [1:0] CRV_SH_QWORD = 2'h3;
	localparam int CRV_SKEW_MAX = 3;
	localparam int CRV_ADDR_W = 21;
	localparam int CRV_LINE_W = 11;
endpackage

/* rtl/crv_vcursor.sv */
`timescale 1ns/100ps
module crv_vcursor
	import crv_pkg::*;
(
	input wire logic clk_i, // 100 MHz clock
	input wire logic sys_rst_i, // Synchronous reset, high
	input wire logic idx_wr_i, // Index port write strobe
	input wire logic data_wr_i, // Data port write strobe
	input wire logic data_rd_i, // Data port read strobe
	input wire logic [7:0] host_data_i, // Host write data
	output logic [7:0] host_data_o, // Read data, one cycle after strobe
	output logic reg_hit_o, // Index selects a register held here
	output logic [7:0] timing_wr_mask_o, // Writable bits of indices 0-7
	input wire logic char_ce_i, // Character clock enable
	input wire logic line_ce_i, // Horizontal retrace enable, once a line
	input wire logic h_display_i, // Horizontal active display
	input wire logic [10:0] vtotal_i, // Vertical total value
	input wire logic [7:0] timing_overflow_register_i, // Overflow bits
	input wire logic [7:0] vertical_extension_register_i, // Bit 10 source
	input wire logic [4:0] start_address_extension_i, // Address bits 20-16
	input wire logic [1:0] refresh_override_register_i, // Refresh override
	input wire logic [7:0] pitch_extension_register_i, // Offset bits 9-8
	input wire logic [7:0] pitch_bit8_register_i, // Offset bit 8 fallback
	input wire logic [7:0] address_mode_force_register_i, // Bit 3 forces dword
	input wire logic word_mode_i, // Word addressing selected
	input wire logic dword_mode_i, // Doubleword addressing selected
	input wire logic qword_mode_i, // Quadword addressing selected
	input wire logic vertical_irq_master_enable_i, // Master interrupt enable
	output logic vsync_o, // Vertical sync
	output logic v_display_o, // Vertical active display
	output logic irq_o, // Vertical interrupt request
	output logic [20:0] mem_addr_o, // Video memory address
	output logic [4:0] row_scan_o, // Row scan within character cell
	output logic cursor_o, // Skewed text cursor
	output logic [1:0] byte_pan_o, // Byte pan amount
	output logic [2:0] refresh_cycles_o, // Refresh cycles per line
	output logic line_doubling_enable_o // Line doubling active
);

	//--------------------------------------------------
	// Register file
	//--------------------------------------------------
	logic [7:0] crtc_index;
	logic [7:0] crtc_reg [CRV_IDX_PRESET:CRV_IDX_PITCH];

	function automatic logic [7:0] read_mask(input logic [7:0] idx);
		logic [7:0] m;
		m = CRV_MASK_NONE;
		if (idx == CRV_IDX_PRESET) begin
			m = CRV_MASK_PRESET;
		end else if (idx == CRV_IDX_CSTART) begin
			m = CRV_MASK_CSTART;
		end else if (idx == CRV_IDX_CEND) begin
			m = CRV_MASK_CEND;
		end else if (idx >= CRV_IDX_MAXSCAN && idx <= CRV_IDX_PITCH) begin
			m = CRV_MASK_ALL;
		end
		return m;
	endfunction

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			crtc_index <= CRV_RST_ZERO;
		end else if (idx_wr_i) begin
			crtc_index <= host_data_i; // RULE_23
		end
	end

	generate
		for (genvar g = CRV_IDX_PRESET; g <= CRV_IDX_PITCH; g++) begin : g_reg
			localparam logic [7:0] GIDX = 8'(g);
			localparam logic [7:0] GRST =
				(GIDX == CRV_IDX_VSEND) ? CRV_RST_VSEND : CRV_RST_ZERO;
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					crtc_reg[g] <= GRST;
				end else if (data_wr_i && crtc_index == GIDX) begin
					crtc_reg[g] <= host_data_i & read_mask(GIDX); // RULE_23
				end
			end
		end
	endgenerate

	assign reg_hit_o = (read_mask(crtc_index) != CRV_MASK_NONE);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			host_data_o <= CRV_RST_ZERO;
		end else if (data_rd_i) begin
			host_data_o <= reg_hit_o ? crtc_reg[crtc_index] : CRV_RST_ZERO;
		end
	end

	//--------------------------------------------------
	// Field decode
	//--------------------------------------------------
	logic timing_write_lock;
	logic vertical_irq_clear;
	logic vertical_irq_disable;
	logic cursor_disable;
	logic [1:0] cursor_delay;
	logic [4:0] preset_row;
	logic [4:0] max_scan;
	logic [4:0] cur_start;
	logic [4:0] cur_end;
	logic [20:0] start_addr;
	logic [20:0] cursor_loc;
	logic [10:0] vs_start;
	logic [10:0] vd_end;
	logic [9:0] pitch;
	logic [1:0] pitch_hi;
	logic [1:0] row_shift;
	logic [20:0] row_step;
	logic dword_sel;

	assign timing_write_lock = crtc_reg[CRV_IDX_VSEND][CRV_LOCK_BIT];
	assign vertical_irq_clear = crtc_reg[CRV_IDX_VSEND][CRV_CLR_BIT];
	assign vertical_irq_disable = crtc_reg[CRV_IDX_VSEND][CRV_DIS_BIT];
	assign cursor_disable = crtc_reg[CRV_IDX_CSTART][CRV_COFF_BIT];
	assign cursor_delay = crtc_reg[CRV_IDX_CEND][CRV_PAN_MSB:CRV_PAN_LSB];
	assign preset_row = crtc_reg[CRV_IDX_PRESET][CRV_ROW_MSB:CRV_ROW_LSB];
	assign max_scan = crtc_reg[CRV_IDX_MAXSCAN][CRV_ROW_MSB:CRV_ROW_LSB];
	assign cur_start = crtc_reg[CRV_IDX_CSTART][CRV_ROW_MSB:CRV_ROW_LSB];
	assign cur_end = crtc_reg[CRV_IDX_CEND][CRV_ROW_MSB:CRV_ROW_LSB];
	assign byte_pan_o = crtc_reg[CRV_IDX_PRESET][CRV_PAN_MSB:CRV_PAN_LSB];
	assign line_doubling_enable_o = crtc_reg[CRV_IDX_MAXSCAN][CRV_DBL_BIT];

	// Display start and cursor location, both topped by the start address extension bits
	assign start_addr = {start_address_extension_i[CRV_EXT_MSB:0],
		crtc_reg[CRV_IDX_STARTH], crtc_reg[CRV_IDX_STARTL]}; // RULE_09
	assign cursor_loc = {start_address_extension_i[CRV_EXT_MSB:0],
		crtc_reg[CRV_IDX_CLOCH], crtc_reg[CRV_IDX_CLOCL]}; // RULE_10

	// Line values: bits 8 and 9 from overflow, bit 10 from extension
	assign vs_start = {vertical_extension_register_i[4],
		timing_overflow_register_i[7], timing_overflow_register_i[2],
		crtc_reg[CRV_IDX_VSSTART]}; // RULE_11
	assign vd_end = {vertical_extension_register_i[1],
		timing_overflow_register_i[6], timing_overflow_register_i[1],
		crtc_reg[CRV_IDX_VDEND]}; // RULE_19

	always_comb begin
		pitch_hi = pitch_extension_register_i[CRV_PEXT_MSB:CRV_PEXT_LSB];
		if (pitch_hi == 2'b00) begin
			pitch_hi = {1'b0, pitch_bit8_register_i[CRV_P8_BIT]}; // RULE_21
		end
	end
	assign pitch = {pitch_hi, crtc_reg[CRV_IDX_PITCH]};

	assign dword_sel = dword_mode_i | address_mode_force_register_i[3];

	always_comb begin
		if (qword_mode_i) begin
			row_shift = CRV_SH_QWORD;
		end else if (dword_sel) begin
			row_shift = CRV_SH_DWORD; // RULE_22
		end else begin
			row_shift = CRV_SH_WORD;
		end
	end
	assign row_step = 21'({11'h000, pitch} << row_shift); // RULE_20

	//--------------------------------------------------
	// Timing register write lock and refresh select
	//--------------------------------------------------
	always_comb begin
		if (!timing_write_lock) begin
			timing_wr_mask_o = CRV_MASK_ALL;
		end else if (crtc_index == CRV_IDX_OVFL) begin
			timing_wr_mask_o = CRV_OVFL_UNLOCKED; // RULE_18
		end else if (crtc_index <= CRV_IDX_LOCKED_LAST) begin
			timing_wr_mask_o = CRV_MASK_NONE; // RULE_18
		end else begin
			timing_wr_mask_o = CRV_MASK_ALL;
		end
	end

	always_comb begin
		unique case (refresh_override_register_i)
			CRV_OVR_NONE: refresh_cycles_o =
				crtc_reg[CRV_IDX_VSEND][CRV_REF_BIT] ?
				CRV_REF_FIVE : CRV_REF_THREE; // RULE_17
			CRV_OVR_ONE: refresh_cycles_o = CRV_REF_ONE;
			CRV_OVR_THREE: refresh_cycles_o = CRV_REF_THREE;
			default: refresh_cycles_o = CRV_REF_FIVE;
		endcase
	end

	//--------------------------------------------------
	// Vertical counter, sync and display end
	//--------------------------------------------------
	logic [10:0] line_cnt;
	logic frame_end;
	logic next_vsync;

	assign frame_end = (line_cnt == 11'(vtotal_i + 11'h001));

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			line_cnt <= '0;
		end else if (line_ce_i) begin
			line_cnt <= frame_end ? '0 : 11'(line_cnt + 11'h001);
		end
	end

	always_comb begin
		next_vsync = vsync_o;
		if (line_cnt == vs_start) begin
			next_vsync = 1'b1; // RULE_11
		end else if (line_cnt[CRV_VSE_MSB:0] ==
			crtc_reg[CRV_IDX_VSEND][CRV_VSE_MSB:0]) begin
			next_vsync = 1'b0; // RULE_12
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			vsync_o <= 1'b0;
		end else if (line_ce_i) begin
			vsync_o <= next_vsync;
		end
	end

	assign v_display_o = (line_cnt <= vd_end); // RULE_19

	//--------------------------------------------------
	// Vertical interrupt
	//--------------------------------------------------
	logic irq_ff;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_ff <= 1'b0;
		end else if (!vertical_irq_clear) begin
			irq_ff <= 1'b0; // RULE_14
		end else if (line_ce_i && line_cnt == vd_end) begin
			irq_ff <= 1'b1; // RULE_13
		end
	end

	assign irq_o = irq_ff & ~vertical_irq_disable &
		vertical_irq_master_enable_i; // RULE_16

	//--------------------------------------------------
	// Row scan and memory address
	//--------------------------------------------------
	logic [4:0] row_scan;
	logic [20:0] row_addr;
	logic [20:0] next_row_addr;
	logic dbl_phase;
	logic dbl_hold;

	// First pass of a doubled line holds row scan and row address
	assign dbl_hold = line_doubling_enable_o && !dbl_phase; // RULE_04

	// Address of the row that begins at this line enable
	always_comb begin
		next_row_addr = row_addr;
		if (frame_end) begin
			next_row_addr = 21'(start_addr + {19'h00000, byte_pan_o}); // RULE_02
		end else if (!dbl_hold && row_scan >= max_scan) begin
			next_row_addr = 21'(row_addr + row_step); // RULE_20
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			row_scan <= '0;
			row_addr <= '0;
			dbl_phase <= 1'b0;
		end else if (line_ce_i) begin
			row_addr <= next_row_addr;
			if (frame_end) begin
				row_scan <= preset_row; // RULE_01
				dbl_phase <= 1'b0;
			end else if (dbl_hold) begin
				dbl_phase <= 1'b1; // RULE_04
			end else begin
				dbl_phase <= 1'b0;
				if (row_scan >= max_scan) begin
					row_scan <= '0; // RULE_03
				end else begin
					row_scan <= 5'(row_scan + 5'h01); // RULE_03
				end
			end
		end
	end

	assign row_scan_o = row_scan;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mem_addr_o <= '0;
		end else if (line_ce_i) begin
			mem_addr_o <= next_row_addr; // RULE_09
		end else if (char_ce_i && h_display_i) begin
			mem_addr_o <= 21'(mem_addr_o + 21'h000001);
		end
	end

	//--------------------------------------------------
	// Text cursor and skew
	//--------------------------------------------------
	logic cursor_raw;
	logic [CRV_SKEW_MAX:0] cursor_pipe;

	assign cursor_raw = h_display_i && v_display_o && !cursor_disable && // RULE_06
		(cur_start <= cur_end) && // RULE_05
		(row_scan > cur_start) && // RULE_05
		(row_scan <= cur_end) && // RULE_07
		(mem_addr_o == cursor_loc); // RULE_10

	assign cursor_pipe[0] = cursor_raw;

	generate
		for (genvar s = 1; s <= CRV_SKEW_MAX; s++) begin : g_skew
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					cursor_pipe[s] <= 1'b0;
				end else if (char_ce_i) begin
					cursor_pipe[s] <= cursor_pipe[s-1]; // RULE_08
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cursor_o <= 1'b0;
		end else begin
			cursor_o <= cursor_pipe[cursor_delay]; // RULE_08
		end
	end

endmodule

/* tb/crv_checker.sv */
`timescale 1ns/100ps
module crv_checker
	import crv_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic idx_wr_i,
	input wire logic data_wr_i,
	input wire logic data_rd_i,
	input wire logic [7:0] host_data_i,
	input wire logic [7:0] host_data_o,
	input wire logic [7:0] timing_wr_mask_o,
	input wire logic char_ce_i,
	input wire logic line_ce_i,
	input wire logic [1:0] refresh_override_register_i,
	input wire logic vertical_irq_master_enable_i,
	input wire logic vsync_o,
	input wire logic irq_o,
	input wire logic cursor_o,
	input wire logic [1:0] byte_pan_o,
	input wire logic [2:0] refresh_cycles_o,
	input wire logic line_doubling_enable_o
);
	logic [7:0] idx, pre, mx, cs, ce, vr;
	logic [3:0] offc;
	logic off;
	// ----------------------------------------
	// Shadow of the host registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			idx <= 8'h00;
			pre <= 8'h00;
			mx <= 8'h00;
			cs <= 8'h00;
			ce <= 8'h00;
			vr <= 8'h80;
		end else begin
			if (idx_wr_i) begin
				idx <= host_data_i;
			end
			if (data_wr_i) begin
				case (idx)
				8'h08: pre <= host_data_i;
				8'h09: mx <= host_data_i;
				8'h0A: cs <= host_data_i;
				8'h0B: ce <= host_data_i;
				8'h11: vr <= host_data_i;
				default: ;
				endcase
			end
		end
	end
	assign off = cs[5] || (cs[4:0] > ce[4:0]);
	// Character clocks seen while no cursor may show
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !off) begin
			offc <= 4'h0;
		end else if (char_ce_i && offc != 4'hF) begin
			offc <= offc + 4'h1;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_vs_hold; !line_ce_i |=> $stable(vsync_o); endproperty
	a_vs_hold: assert property (p_vs_hold)
		else $error("vsync moved without a line enable");
	property p_rd_hold; !data_rd_i |=> $stable(host_data_o); endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	property p_ref;
		refresh_override_register_i == 2'h0 |->
			refresh_cycles_o == (vr[6] ? 3'h5 : 3'h3);
	endproperty
	a_ref: assert property (p_ref)
		else $error("refresh count wrong for select bit");
	property p_pan; byte_pan_o == pre[6:5]; endproperty
	a_pan: assert property (p_pan)
		else $error("byte pan differs from register");
	property p_dbl; line_doubling_enable_o == mx[7]; endproperty
	a_dbl: assert property (p_dbl)
		else $error("line doubling differs from register");
	property p_mask;
		idx <= 8'h07 |-> timing_wr_mask_o ==
			(!vr[7] ? 8'hFF : (idx == 8'h07 ? 8'h10 : 8'h00));
	endproperty
	a_mask: assert property (p_mask)
		else $error("timing write mask wrong");
	property p_cur_off; offc > 4'h7 |-> !cursor_o; endproperty
	a_cur_off: assert property (p_cur_off)
		else $error("cursor shown while off");
	property p_irq_clr; !vr[4] [*2] |-> !irq_o; endproperty
	a_irq_clr: assert property (p_irq_clr)
		else $error("interrupt not held clear");
	property p_irq_en;
		vr[5] || !vertical_irq_master_enable_i |-> !irq_o;
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("interrupt not blocked");
	c_vs: cover property ($rose(vsync_o));
	c_irq: cover property ($rose(irq_o));
	c_cur: cover property ($rose(cursor_o));
endmodule

/* tb/crv_monitor.sv */
`timescale 1ns/100ps
module crv_monitor (
	input wire logic clk_i, // System clock
	input wire logic line_ce_i, // Line enable
	input wire logic vsync_i, // Vertical sync seen
	input wire logic v_display_i, // Vertical active display seen
	output logic [7:0] vs_lines_o, // Lines in last sync pulse
	output logic [10:0] de_lines_o // Active lines in last frame
);
	logic [7:0] vs_cnt = 8'h00;
	logic [10:0] de_cnt = 11'h000;
	logic vs_q = 1'b0;
	// Measure sync width and active lines per frame
	always_ff @(posedge clk_i) begin
		vs_q <= vsync_i;
		if (vs_q && !vsync_i) begin
			vs_lines_o <= vs_cnt;
			vs_cnt <= 8'h00;
		end else if (line_ce_i && vsync_i) begin
			vs_cnt <= vs_cnt + 8'h01;
		end
		if (!vs_q && vsync_i) begin
			de_lines_o <= de_cnt;
			de_cnt <= 11'h000;
		end else if (line_ce_i && v_display_i) begin
			de_cnt <= de_cnt + 11'h001;
		end
	end
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import crv_pkg::*;
	logic clk_i, sys_rst_i, idx_wr_i, data_wr_i, data_rd_i;
	logic char_ce_i, line_ce_i, h_display_i, vertical_irq_master_enable_i;
	logic word_mode_i, dword_mode_i, qword_mode_i;
	logic [7:0] host_data_i, timing_overflow_register_i;
	logic [7:0] vertical_extension_register_i, pitch_extension_register_i;
	logic [7:0] pitch_bit8_register_i, address_mode_force_register_i;
	logic [10:0] vtotal_i, de_lines;
	logic [4:0] start_address_extension_i, row_scan_o;
	logic [1:0] refresh_override_register_i, byte_pan_o;
	logic [7:0] host_data_o, timing_wr_mask_o, vs_lines, rv, w;
	logic reg_hit_o, vsync_o, v_display_o, irq_o, cursor_o;
	logic line_doubling_enable_o;
	logic [20:0] mem_addr_o;
	logic [2:0] refresh_cycles_o;
	int fail_count = 0, compares = 0, seed = 66, curs = 0;
	int cc = 0, cpos = -1, cpos0 = 0;
	logic [1:0] sk;
	crv_vcursor dut (.*);
	crv_monitor mon (.clk_i(clk_i), .line_ce_i(line_ce_i),
		.vsync_i(vsync_o), .v_display_i(v_display_o),
		.vs_lines_o(vs_lines), .de_lines_o(de_lines));
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (cursor_o === 1'b1) begin
			curs++;
		end
		if (line_ce_i) begin
			cc = 0;
		end else if (char_ce_i) begin
			cc++;
		end
		if (cursor_o === 1'b1 && cpos < 0) begin
			cpos = cc;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude;
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		idx_wr_i = 1;
		host_data_i = a;
		tick(1);
		idx_wr_i = 0;
		data_wr_i = 1;
		host_data_i = d;
		tick(1);
		data_wr_i = 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		idx_wr_i = 1;
		host_data_i = a;
		tick(1);
		idx_wr_i = 0;
		data_rd_i = 1;
		tick(1);
		data_rd_i = 0;
		d = host_data_o;
	endtask
	task automatic lines(input int n);
		repeat (n) begin
			line_ce_i = 1;
			tick(1);
			line_ce_i = 0;
			h_display_i = 1;
			char_ce_i = 1;
			tick(8);
			h_display_i = 0;
			char_ce_i = 0;
			tick(2);
		end
	endtask
	function automatic logic [7:0] rmask(input logic [7:0] a);
		case (a)
		8'h08, 8'h0B: return 8'h7F;
		8'h0A: return 8'h3F;
		default: return 8'hFF;
		endcase
	endfunction
	function automatic logic [2:0] refcyc(input logic [1:0] ov, input logic s);
		case (ov)
		2'h0: return s ? 3'h5 : 3'h3;
		2'h1: return 3'h1;
		2'h2: return 3'h3;
		default: return 3'h5;
		endcase
	endfunction
	function automatic logic [20:0] rowstep(input logic [7:0] lo);
		logic [1:0] hi;
		logic [1:0] sh;
		logic dw;
		hi = pitch_extension_register_i[5:4];
		if (hi == 2'b00) begin
			hi = {1'b0, pitch_bit8_register_i[2]};
		end
		dw = dword_mode_i | address_mode_force_register_i[3];
		sh = 2'h1;
		if (qword_mode_i) begin
			sh = 2'h3;
		end else if (dw) begin
			sh = 2'h2;
		end
		return 21'({hi, lo}) << sh;
	endfunction
	// Row geometry from one frame start, cursor one cell into row 0
	task automatic geom(input logic [1:0] s);
		logic [20:0] ea, st;
		logic [15:0] loc;
		logic [4:0] er;
		logic [1:0] pan;
		logic ph, dbl;
		pan = 2'($random(seed));
		dbl = 1'($random(seed));
		er = 5'($random(seed) & 1);
		pitch_extension_register_i = 8'($random(seed));
		pitch_bit8_register_i = 8'($random(seed));
		address_mode_force_register_i = 8'($random(seed));
		{qword_mode_i, dword_mode_i, word_mode_i} = 3'($random(seed));
		w = 8'($random(seed));
		loc = 16'(w + pan + 1);
		wr(8'h08, {1'b0, pan, er});
		wr(8'h09, {dbl, 2'b00, 5'd3});
		wr(8'h0A, 8'h01);
		wr(8'h0B, {1'b0, s, 5'd3});
		wr(8'h0C, 8'h00);
		wr(8'h0D, w);
		wr(8'h0E, loc[15:8]);
		wr(8'h0F, loc[7:0]);
		rv = 8'($random(seed));
		wr(8'h13, rv);
		st = rowstep(rv);
		ea = 21'(w + pan);
		lines(42);
		ph = 0;
		cpos = -1;
		chk(row_scan_o, er);
		chk(mem_addr_o, ea + 21'd8);
		for (int k = 0; k < 12; k++) begin
			if (dbl && !ph) begin
				ph = 1;
			end else begin
				ph = 0;
				if (er >= 5'd3) begin
					er = 0;
					ea = ea + st;
				end else begin
					er++;
				end
			end
			lines(1);
			chk(row_scan_o, er);
			chk(mem_addr_o, ea + 21'd8);
		end
		lines(30);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
	initial begin
		{idx_wr_i, data_wr_i, data_rd_i, char_ce_i, line_ce_i} = 0;
		{h_display_i, word_mode_i, dword_mode_i, qword_mode_i} = 0;
		{host_data_i, timing_overflow_register_i} = 0;
		{vertical_extension_register_i, start_address_extension_i} = 0;
		{refresh_override_register_i, vertical_irq_master_enable_i} = 0;
		pitch_extension_register_i = $random(seed);
		pitch_bit8_register_i = $random(seed);
		address_mode_force_register_i = $random(seed);
		vtotal_i = 11'd40;
		sys_rst_i = 1;
		tick(4);
		sys_rst_i = 0;
		for (int i = 8; i < 21; i++) begin
			rd(i[7:0], rv);
			chk(rv, i == 17 ? 8'h80 : 8'h00);
		end
		chk(reg_hit_o, 0);
		rd(8'h07, rv);
		chk(timing_wr_mask_o, 8'h10);
		rd(8'h03, rv);
		chk(timing_wr_mask_o, 8'h00);
		for (int i = 8; i < 21; i++) begin
			rv = $random(seed);
			rv[7] = (i == 17) ? 1'b0 : rv[7];
			wr(i[7:0], rv);
			rd(i[7:0], w);
			chk(w, i == 20 ? 8'h00 : rv & rmask(i[7:0]));
		end
		rd(8'h07, rv);
		chk(timing_wr_mask_o, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			refresh_override_register_i = i[1:0];
			wr(8'h11, {1'b0, i[2], 6'h10});
			chk(refresh_cycles_o, refcyc(i[1:0], i[2]));
		end
		refresh_override_register_i = 0;
		vertical_irq_master_enable_i = 1;
		w = ($random(seed) & 8'h07) + 8'h03;
		rv = 8'd25 + w;
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h07);
		wr(8'h0A, 8'h01);
		wr(8'h0B, 8'h03);
		wr(8'h0C, 8'h00);
		wr(8'h0D, 8'h10);
		wr(8'h0E, 8'h00);
		wr(8'h0F, 8'h12);
		wr(8'h10, 8'd25);
		wr(8'h11, {4'h1, rv[3:0]});
		wr(8'h12, 8'd20);
		wr(8'h13, 8'h04);
		curs = 0;
		lines(84);
		chk(vs_lines, w);
		chk(de_lines, 11'd21);
		chk(curs != 0, 1);
		chk(irq_o, 1);
		rd(8'h11, rv);
		wr(8'h11, rv & 8'hEF);
		tick(1);
		chk(irq_o, 0);
		wr(8'h11, rv);
		lines(42);
		chk(irq_o, 1);
		wr(8'h11, rv | 8'h20);
		chk(irq_o, 0);
		wr(8'h11, rv);
		vertical_irq_master_enable_i = 0;
		#1;
		chk(irq_o, 0);
		for (int i = 0; i < 2; i++) begin
			wr(8'h0A, i == 0 ? 8'h21 : 8'h04);
			curs = 0;
			lines(42);
			chk(curs, 0);
		end
		geom(2'h0);
		cpos0 = cpos;
		chk(cpos0, 3);
		sk = 2'({$random(seed)} % 3 + 1);
		geom(sk);
		chk(cpos - cpos0, sk);
		conclude();
	end
endmodule
bind crv_vcursor crv_checker u_chk (.*);
